// ===== lsmc_defines.svh
/*
  timing counts, field codes and reset values of the light sensor measurement control.
  assumes a 125 MHz core clock; included by the watchdog and top design modules.
*/
`ifndef LSMC_DEFINES_SVH
`define LSMC_DEFINES_SVH

`define LSMC_CLK_MHZ          125
`define LSMC_TIMEOUT_MS       28
`define LSMC_INT_SHORT_MS     100
`define LSMC_INT_LONG_MS      800
`define LSMC_DATA_READY_MS    3
`define LSMC_ASSESS_MS        10
`define LSMC_CYC_PER_MS       (`LSMC_CLK_MHZ * 1000)
`define LSMC_TIMEOUT_CYC      (`LSMC_TIMEOUT_MS * `LSMC_CYC_PER_MS)
`define LSMC_INT_SHORT_CYC    (`LSMC_INT_SHORT_MS * `LSMC_CYC_PER_MS)
`define LSMC_INT_LONG_CYC     (`LSMC_INT_LONG_MS * `LSMC_CYC_PER_MS)
`define LSMC_DATA_READY_CYC   (`LSMC_DATA_READY_MS * `LSMC_CYC_PER_MS)
`define LSMC_ASSESS_CYC       (`LSMC_ASSESS_MS * `LSMC_CYC_PER_MS)

`define LSMC_RANGE_AUTO       4'hc
`define LSMC_RANGE_MAX        4'hb
`define LSMC_RANGE_RST        4'hc
`define LSMC_MODE_SHUTDOWN    2'h0
`define LSMC_MODE_SINGLE      2'h1
`define LSMC_MODE_CONT        2'h2
`define LSMC_MODE_CONT_ALT    2'h3
`define LSMC_LOW_THRESH       20'h20000
`define LSMC_VLOW_THRESH      20'h04000
`define LSMC_HIGH_THRESH      20'hc0000

`endif

// ===== lsmc_pkg.sv
/*
  types of the light sensor measurement control.
  assumes lsmc_defines.svh is in the include path.
*/
package lsmc_pkg;
  typedef enum logic [2:0]
  {
    LSMC_IDLE    = 3'b000,
    LSMC_ASSESS  = 3'b001,
    LSMC_INTEG   = 3'b010,
    LSMC_SETTLE  = 3'b011,
    LSMC_DONE    = 3'b100
  } lsmc_state_t;
endpackage

// ===== lsmc_bus_watchdog.sv
/*
  stuck-low bus clock watchdog: synchronises the pin and pulses a bus reset.
  assumes scl arrives asynchronously from the bus pin.
*/
`timescale 1ns/1ps
`include "lsmc_defines.svh"

module lsmc_bus_watchdog #(
  parameter int unsigned TIMEOUT_CYC = `LSMC_TIMEOUT_CYC
)(
  input  wire logic clk_i,        // core clock
  input  wire logic rst_i,        // synchronous reset
  input  wire logic scl_i,        // bus clock pin
  output logic      scl_o,        // filtered bus clock level
  output logic      bus_reset_o   // one-cycle bus state machine reset
);
  typedef struct packed
  {
    logic [2:0]  sync;
    logic        lvl;
    logic [31:0] cnt;
    logic        rst;
  } lsmc_wd_t;

  lsmc_wd_t wd_r;
  lsmc_wd_t wd_nxt;

  // refuse a timeout the counter cannot reach in a meaningful way
  if (TIMEOUT_CYC < 2)
    $error("timeout count too small");

  // three stage sync, level follows when stages two and three agree
  always_comb
  begin
    wd_nxt      = wd_r;
    wd_nxt.sync = {wd_r.sync[1:0], scl_i};
    wd_nxt.rst  = 1'b0;
    if (wd_r.sync[1] == wd_r.sync[2])
      wd_nxt.lvl = wd_r.sync[2];
    if (wd_r.lvl)
      wd_nxt.cnt = '0;
    else if (wd_r.cnt == TIMEOUT_CYC - 1)
    begin
      wd_nxt.rst = 1'b1;
      wd_nxt.cnt = '0;
    end
    else
      wd_nxt.cnt = wd_r.cnt + 32'h1;
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wd_r <= '{sync: 3'h7, lvl: 1'b1, cnt: 32'h0, rst: 1'b0};
    else
      wd_r <= wd_nxt;
  end

  assign scl_o       = wd_r.lvl;
  assign bus_reset_o = wd_r.rst;
endmodule

// ===== lsmc_top.sv
/*
  light sensor measurement sequencer: shutdown, single shot and continuous modes,
  two integration times, automatic range selection and result handover.
  assumes a bus slave elsewhere decodes config writes and reads the result ports;
  the analog front end supplies a converted count on adc_valid_i.
*/
`timescale 1ns/1ps
`include "lsmc_defines.svh"

// Operation
// - bus state machine resets after clock held low for 28 ms.
// - each measurement integrates for 100 ms or 800 ms.
// - conversion time select set to one chooses 800 ms.
// - range number field 1100b selects automatic range mode.
// - automatic mode picks next range itself from previous result.
// - after reset device is in shutdown, no measuring.
// - continuous and single-shot measurement modes are supported.
// - each completed measurement is presented as a lux result for reading; auto mode drops an overranged count below the top range.
// - writing mode 00 enters shutdown and stops conversions.
// - result readable no earlier than integration time plus 3 ms.
// - automatic mode starts with a 10 ms range assessment.
module lsmc_top #(
  parameter int unsigned TIMEOUT_CYC    = `LSMC_TIMEOUT_CYC,
  parameter int unsigned INT_SHORT_CYC  = `LSMC_INT_SHORT_CYC,
  parameter int unsigned INT_LONG_CYC   = `LSMC_INT_LONG_CYC,
  parameter int unsigned READY_CYC      = `LSMC_DATA_READY_CYC,
  parameter int unsigned ASSESS_CYC     = `LSMC_ASSESS_CYC
)(
  input  wire logic        clk_i,          // core clock, 125 MHz
  input  wire logic        rst_i,          // synchronous reset, active high
  input  wire logic        scl_i,          // bus clock pin
  input  wire logic        cfg_wr_i,       // config write strobe from bus slave
  input  wire logic [1:0]  mode_i,         // operating mode field
  input  wire logic        conversion_time_select_i, // 1 selects long integration
  input  wire logic [3:0]  range_number_field_i,     // full scale range or auto
  input  wire logic        adc_valid_i,    // front end count valid pulse
  input  wire logic [19:0] adc_count_i,    // front end count for active range
  output logic             integrate_o,    // front end integrating
  output logic [3:0]       active_range_o, // range used by front end
  output logic             bus_reset_o,    // bus state machine reset pulse
  output logic [1:0]       mode_o,         // current mode readback
  output logic [3:0]       result_exp_o,   // lux result exponent
  output logic [11:0]      result_mant_o,  // lux result mantissa
  output logic             result_ready_o  // new result flag, level
);
  typedef struct packed
  {
    lsmc_pkg::lsmc_state_t st;
    logic [1:0]  mode;
    logic        ct;
    logic [3:0]  rn;
    logic        ct_act;
    logic        auto_act;
    logic [3:0]  range;
    logic [31:0] cnt;
    logic [19:0] sample;
    logic [3:0]  exp;
    logic [11:0] mant;
    logic        ready;
    logic        go;
  } lsmc_core_t;

  lsmc_core_t s_r;
  lsmc_core_t s_nxt;

  // refuse counts the sequencer cannot serve: the long integration must outlast the short one
  if (INT_SHORT_CYC < 1 || INT_LONG_CYC <= INT_SHORT_CYC || READY_CYC < 1 || ASSESS_CYC < 1)
    $error("timing counts not usable");

  // next range from a finished count in automatic mode
  // up one step near full scale, down one or two when the count is low;
  // the bounds tests keep the range inside 0..11 whatever the count
  function automatic logic [3:0] lsmc_next_range(input logic [3:0] rng, input logic [19:0] c);
    logic [3:0] r;
    r = rng;
    if (c >= `LSMC_HIGH_THRESH && rng < `LSMC_RANGE_MAX)
      r = rng + 4'h1;
    else if (c < `LSMC_VLOW_THRESH && rng > 4'h1)
      r = rng - 4'h2;
    else if (c < `LSMC_LOW_THRESH && rng > 4'h0)
      r = rng - 4'h1;
    return r;
  endfunction

  // stuck clock watchdog
  // only the timeout pulse leaves it; the filtered clock level is not needed here
  lsmc_bus_watchdog #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_wd (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .scl_i       (scl_i),
    .scl_o       (),
    .bus_reset_o (bus_reset_o)
  );

  // sequencer
  always_comb
  begin
    s_nxt = s_r;
    // a single-shot request left pending is harmless: every write rewrites it
    if (cfg_wr_i)
    begin
      s_nxt.mode = mode_i;
      s_nxt.ct   = conversion_time_select_i;
      s_nxt.rn   = range_number_field_i;
      s_nxt.go   = (mode_i == `LSMC_MODE_SINGLE);
    end
    case (s_r.st)
      // idle: latch the settings for this conversion; later writes wait for the next start
      lsmc_pkg::LSMC_IDLE:
      begin
        if (s_r.mode != `LSMC_MODE_SHUTDOWN && (s_r.mode != `LSMC_MODE_SINGLE || s_r.go))
        begin
          s_nxt.go       = 1'b0;
          s_nxt.ct_act   = s_r.ct;
          s_nxt.auto_act = (s_r.rn == `LSMC_RANGE_AUTO);
          s_nxt.cnt      = '0;
          // first start in auto mode runs the short assessment at the top range
          if (s_r.rn == `LSMC_RANGE_AUTO && !s_r.auto_act)
          begin
            s_nxt.range = `LSMC_RANGE_MAX;
            s_nxt.st    = lsmc_pkg::LSMC_ASSESS;
          end
          else
          begin
            if (s_r.rn != `LSMC_RANGE_AUTO)
              s_nxt.range = (s_r.rn > `LSMC_RANGE_MAX) ? `LSMC_RANGE_MAX : s_r.rn;
            s_nxt.st = lsmc_pkg::LSMC_INTEG;
          end
        end
      end
      // assessment: keep the last count, then pick the range from the bottom up
      lsmc_pkg::LSMC_ASSESS:
      begin
        s_nxt.cnt = s_r.cnt + 32'h1;
        if (adc_valid_i)
          s_nxt.sample = adc_count_i;
        if (s_r.cnt == ASSESS_CYC - 1)
        begin
          s_nxt.range = lsmc_next_range(4'h0, s_r.sample);
          s_nxt.cnt   = '0;
          s_nxt.st    = lsmc_pkg::LSMC_INTEG;
        end
      end
      // integration: the last valid front end count of the window is kept
      lsmc_pkg::LSMC_INTEG:
      begin
        s_nxt.cnt = s_r.cnt + 32'h1;
        if (adc_valid_i)
          s_nxt.sample = adc_count_i;
        if (s_r.cnt == (s_r.ct_act ? INT_LONG_CYC : INT_SHORT_CYC) - 1)
        begin
          s_nxt.cnt = '0;
          s_nxt.st  = lsmc_pkg::LSMC_SETTLE;
        end
      end
      // settle: hold the result back for the data ready time
      lsmc_pkg::LSMC_SETTLE:
      begin
        s_nxt.cnt = s_r.cnt + 32'h1;
        if (s_r.cnt == READY_CYC - 1)
        begin
          s_nxt.cnt = '0;
          // an overranged count in auto mode below the top range is dropped and retaken one range higher
          if (s_r.auto_act && s_r.sample == 20'hfffff && s_r.range < `LSMC_RANGE_MAX)
          begin
            s_nxt.range = s_r.range + 4'h1;                  // overrange: retake, not reported
            s_nxt.st    = lsmc_pkg::LSMC_INTEG;
          end
          else
            s_nxt.st = lsmc_pkg::LSMC_DONE;
        end
      end
      // done: publish the result; single shot falls back to shutdown unless a write lands now
      lsmc_pkg::LSMC_DONE:
      begin
        s_nxt.exp   = s_r.range;
        s_nxt.mant  = s_r.sample[19:8];
        s_nxt.ready = 1'b1;
        if (s_r.auto_act)
          s_nxt.range = lsmc_next_range(s_r.range, s_r.sample);
        if (s_r.mode == `LSMC_MODE_SINGLE)
          s_nxt.mode = cfg_wr_i ? mode_i : `LSMC_MODE_SHUTDOWN;
        s_nxt.st = lsmc_pkg::LSMC_IDLE;
      end
      default:
        s_nxt.st = lsmc_pkg::LSMC_IDLE;
    endcase
    // shutdown write aborts any conversion
    if (cfg_wr_i && mode_i == `LSMC_MODE_SHUTDOWN)
    begin
      s_nxt.st       = lsmc_pkg::LSMC_IDLE;
      s_nxt.cnt      = '0;
      s_nxt.auto_act = 1'b0;
    end
    // a read of the result through the bus clock activity is not tracked; a new config write clears ready, except in the done cycle
    if (cfg_wr_i && s_r.st != lsmc_pkg::LSMC_DONE)
      s_nxt.ready = 1'b0;
  end

  // state register, shutdown after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '{st: lsmc_pkg::LSMC_IDLE, mode: `LSMC_MODE_SHUTDOWN, ct: 1'b0, rn: `LSMC_RANGE_RST,
               ct_act: 1'b0, auto_act: 1'b0, range: `LSMC_RANGE_MAX, cnt: 32'h0, sample: 20'h0,
               exp: 4'h0, mant: 12'h0, ready: 1'b0, go: 1'b0};
    else
      s_r <= s_nxt;
  end

  // outputs
  // the front end runs in assessment as well as in integration
  assign integrate_o    = (s_r.st == lsmc_pkg::LSMC_INTEG) || (s_r.st == lsmc_pkg::LSMC_ASSESS);
  assign active_range_o = s_r.range;
  assign mode_o         = s_r.mode;
  assign result_exp_o   = s_r.exp;
  assign result_mant_o  = s_r.mant;
  assign result_ready_o = s_r.ready;
endmodule

// ===== lsmc_checker.sv
/*
  port checks of the light sensor measurement sequencer.
  assumes it is bound to lsmc_top and receives the same count parameters.
*/
`timescale 1ns/1ps

module lsmc_checker #(
  parameter int unsigned TIMEOUT_CYC   = 50,
  parameter int unsigned INT_SHORT_CYC = 20,
  parameter int unsigned READY_CYC     = 5
)(
  input wire logic       clk_i,          // core clock
  input wire logic       rst_i,          // synchronous reset
  input wire logic       scl_i,          // bus clock pin
  input wire logic       cfg_wr_i,       // config write strobe
  input wire logic [1:0] mode_i,         // written mode
  input wire logic       integrate_o,    // integrating
  input wire logic [3:0] active_range_o, // range in use
  input wire logic       bus_reset_o,    // bus reset pulse
  input wire logic [1:0] mode_o,         // mode readback
  input wire logic       result_ready_o  // result flag
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] run_cnt_r; // cycles since integration began
  logic [31:0] low_cnt_r; // cycles the bus clock pin has been low

  // helper counters
  always_ff @(posedge clk_i)
  begin
    run_cnt_r <= (rst_i || $rose(integrate_o)) ? 32'h1 : run_cnt_r + 32'h1;
    low_cnt_r <= (rst_i || scl_i) ? 32'h0 : low_cnt_r + 32'h1;
  end

  a_reset_idle: assert property ($fell(rst_i) |-> mode_o == 2'h0 && !integrate_o && !result_ready_o)
    else $error("not idle after reset");
  a_start_delay: assert property (cfg_wr_i && mode_i != 2'h0 && mode_o == 2'h0 && !integrate_o |-> ##2 integrate_o)
    else $error("conversion did not start");
  a_stop_on_zero: assert property (cfg_wr_i && mode_i == 2'h0 |=> (!integrate_o && mode_o == 2'h0) [*2])
    else $error("shutdown did not stop");
  a_ready_not_early: assert property ($rose(result_ready_o) |-> run_cnt_r >= INT_SHORT_CYC + READY_CYC)
    else $error("result ready too early");
  a_ready_clear: assert property (cfg_wr_i && result_ready_o && mode_o == 2'h0 && !integrate_o |=> !result_ready_o)
    else $error("ready flag not cleared");
  a_single_back: assert property ($rose(result_ready_o) && $past(mode_o) == 2'h1 |-> mode_o == 2'h0)
    else $error("single shot did not return");
  a_range_legal: assert property (active_range_o <= 4'hb)
    else $error("range out of bounds");
  a_bus_timeout: assert property (bus_reset_o |-> low_cnt_r >= TIMEOUT_CYC)
    else $error("bus reset too early");
  a_bus_pulse: assert property (bus_reset_o |=> !bus_reset_o)
    else $error("bus reset not a pulse");
endmodule

// ===== lsmc_frontend_model.sv
/*
  behavioural front end: converts a light level into counts.
  assumes the sequencer raises integrate_i for each measurement.
*/
`timescale 1ns/1ps

module lsmc_frontend_model (
  input  wire logic        clk_i,              // core clock
  input  wire logic        integrate_i,        // integration request
  input  wire logic [19:0] light_i,            // light level as count
  output logic             adc_valid_o,        // count valid
  output logic [19:0]      adc_count_o         // converted count
);
  // one count per integrating cycle; outside, the inverse shows so a stray capture is seen
  always_ff @(posedge clk_i)
  begin
    adc_valid_o <= integrate_i;
    adc_count_o <= integrate_i ? light_i : ~light_i;
  end
endmodule

// ===== testbench.sv
/*
  self-checking bench of the measurement sequencer with a front end model.
  assumes shortened counts; inputs change on the falling clock edge.
*/
`timescale 1ns/1ps

module testbench;
  localparam int unsigned TO_C = 50, SH_C = 20, LG_C = 40, RD_C = 5, AS_C = 4;
  logic        clk_i = 1'b0, rst_i = 1'b1, scl_i = 1'b1, cfg_wr_i = 1'b0, ct_sel = 1'b0;
  logic [1:0]  mode_sel = 2'h0, mode_o;
  logic [3:0]  rn_sel = 4'h0, r, active_range_o, result_exp_o;
  logic [19:0] light = 20'h0, adc_count;
  logic [11:0] result_mant_o;
  logic [31:0] seed = 32'h9431;
  logic        adc_valid, integrate_o, bus_reset_o, result_ready_o;
  int          fail_count = 0, n_compared = 0, cycles = 0, n, pulses;

  lsmc_top #(.TIMEOUT_CYC(TO_C), .INT_SHORT_CYC(SH_C), .INT_LONG_CYC(LG_C), .READY_CYC(RD_C),
    .ASSESS_CYC(AS_C)) DUT (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .cfg_wr_i(cfg_wr_i),
    .mode_i(mode_sel), .conversion_time_select_i(ct_sel), .range_number_field_i(rn_sel),
    .adc_valid_i(adc_valid), .adc_count_i(adc_count), .integrate_o(integrate_o),
    .active_range_o(active_range_o), .bus_reset_o(bus_reset_o), .mode_o(mode_o),
    .result_exp_o(result_exp_o), .result_mant_o(result_mant_o), .result_ready_o(result_ready_o));
  lsmc_frontend_model u_fe (.clk_i(clk_i), .integrate_i(integrate_o), .light_i(light),
    .adc_valid_o(adc_valid), .adc_count_o(adc_count));

  always #4 clk_i = ~clk_i;

  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cfg(input logic [1:0] m, input logic c, input logic [3:0] rn);
    @(negedge clk_i);
    mode_sel = m;
    ct_sel = c;
    rn_sel = rn;
    cfg_wr_i = 1'b1;
    @(negedge clk_i);
    cfg_wr_i = 1'b0;
  endtask

  task automatic wait_ready();
    n = 0;
    while (result_ready_o !== 1'b1 && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(20'(n < 2000), 20'h1, "result arrived");
  endtask

  task automatic test_done();
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (30) @(negedge clk_i);
    chk(20'({integrate_o, result_ready_o, mode_o, active_range_o}), 20'h0b, "idle state");
    for (int c = 0; c < 2; c++)
    begin
      light = 20'h51234;
      cfg(2'h1, c[0], 4'h3);
      wait_ready();
      chk(20'(n >= (c ? LG_C : SH_C) + RD_C && n <= (c ? LG_C : SH_C) + RD_C + 3), 20'h1, "duration");
    end
    // random single shots, with a config change in mid-conversion
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      r = (seed[3:0] >= 4'hc) ? seed[3:0] - 4'hc : seed[3:0];
      light = {1'b0, seed[26:8]};
      cfg(2'h1, seed[31], r);
      repeat (5) @(negedge clk_i);
      cfg(2'h1, ~seed[31], r ^ 4'h1);
      wait_ready();
      chk(20'(result_exp_o), 20'(r), "exponent");
      chk(20'(result_mant_o), 20'(light[19:8]), "mantissa");
      chk(20'(mode_o), 20'h0, "mode after single");
    end
    // a range number above the top clamps to the top range
    cfg(2'h1, 1'b0, 4'he);
    wait_ready();
    chk(20'(result_exp_o), 20'hb, "range clamp");
    // fixed continuous, then shutdown
    cfg(2'h3, 1'b0, 4'h2);
    wait_ready();
    chk(20'({mode_o, result_exp_o}), 20'h32, "continuous");
    cfg(2'h0, 1'b0, 4'h2);
    chk(20'({integrate_o, mode_o}), 20'h0, "shutdown");
    // auto range under overrange light climbs to the top range
    light = 20'hfffff;
    cfg(2'h2, 1'b0, 4'hc);
    wait_ready();
    chk(20'(result_exp_o), 20'hb, "auto range top");
    chk(20'(n >= AS_C + SH_C + RD_C), 20'h1, "assessment first");
    light = 20'h01000;
    repeat (3 * (SH_C + RD_C + 4)) @(negedge clk_i);
    chk(20'(active_range_o < 4'hb), 20'h1, "auto range down");
    cfg(2'h0, 1'b0, 4'hc);
    chk(20'({integrate_o, mode_o}), 20'h0, "auto shutdown");
    // stuck bus clock, then a toggling one
    pulses = 0;
    for (int k = 0; k < TO_C + 20; k++)
    begin
      @(negedge clk_i);
      scl_i = 1'b0;
      pulses += int'(bus_reset_o === 1'b1);
    end
    chk(20'(pulses), 20'h1, "timeout pulse");
    pulses = 0;
    for (int k = 0; k < 200; k++)
    begin
      @(negedge clk_i);
      scl_i = k[4];
      pulses += int'(bus_reset_o === 1'b1 && k > 8);
    end
    chk(20'(pulses), 20'h0, "no pulse");
    test_done();
  end
endmodule

bind lsmc_top lsmc_checker #(.TIMEOUT_CYC(TIMEOUT_CYC), .INT_SHORT_CYC(INT_SHORT_CYC), .READY_CYC(READY_CYC))
  u_chk (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .cfg_wr_i(cfg_wr_i), .mode_i(mode_i),
  .integrate_o(integrate_o), .active_range_o(active_range_o), .bus_reset_o(bus_reset_o),
  .mode_o(mode_o), .result_ready_o(result_ready_o));
